// >>> design/ethernet_stream_frame_port.sv
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module ethernet_stream_frame_port #(
  parameter logic [1:0] TX_OFFLOAD_BUILD_OPTION = 2'h2
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Register bus.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Transmit control stream from the system.
  input wire logic [31:0] i_txc_tdata,
  input wire logic [3:0] i_txc_tkeep,
  input wire logic i_txc_tvalid,
  input wire logic i_txc_tlast,
  output logic o_txc_tready,
  // Transmit data stream from the system.
  input wire logic [31:0] i_txd_tdata,
  input wire logic [3:0] i_txd_tkeep,
  input wire logic i_txd_tvalid,
  input wire logic i_txd_tlast,
  output logic o_txd_tready,
  // Transmit frame toward the MAC; ready means buffer space remains.
  output logic [31:0] o_mac_tx_data,
  output logic [3:0] o_mac_tx_keep,
  output logic o_mac_tx_valid,
  output logic o_mac_tx_last,
  input wire logic i_mac_tx_ready,
  output logic [1:0] o_mac_tx_offload,
  output logic o_mac_tx_loopback,
  output logic [15:0] o_tx_csum_begin,
  output logic [15:0] o_tx_csum_insert,
  output logic [15:0] o_tx_csum_init,
  // Received frame from the MAC.
  input wire logic [31:0] i_mac_rx_data,
  input wire logic [3:0] i_mac_rx_keep,
  input wire logic i_mac_rx_valid,
  input wire logic i_mac_rx_last,
  output logic o_mac_rx_ready,
  // Receive status stream to the system.
  output logic [31:0] o_rxs_tdata,
  output logic [3:0] o_rxs_tkeep,
  output logic o_rxs_tvalid,
  output logic o_rxs_tlast,
  input wire logic i_rxs_tready,
  // Receive data stream to the system.
  output logic [31:0] o_rxd_tdata,
  output logic [3:0] o_rxd_tkeep,
  output logic o_rxd_tvalid,
  output logic o_rxd_tlast,
  input wire logic i_rxd_tready
);

  typedef struct packed {
    eth_stream_pkg::tx_state_t tx_state;
    logic [2:0] ctrl_idx;
    logic [1:0] csum_field;
    logic txc_ready;
    logic txd_ready;
    logic mtx_valid;
    logic [31:0] mtx_data;
    logic [3:0] mtx_keep;
    logic mtx_last;
    logic [1:0] offload;
    logic loopback;
    logic [15:0] cs_begin;
    logic [15:0] cs_insert;
    logic [15:0] cs_init;
    logic [15:0] tx_frames;
    logic [15:0] ignored;
    eth_stream_pkg::rx_state_t rx_state;
    logic mrx_ready;
    logic [9:0] rx_words;
    logic [15:0] rx_bytes;
    logic [3:0] rx_last_keep;
    logic [2:0] rxs_idx;
    logic rxs_valid;
    logic [31:0] rxs_data;
    logic rxs_last;
    logic [9:0] rd_ptr;
    logic rxd_valid;
    logic [31:0] rxd_data;
    logic [3:0] rxd_keep;
    logic rxd_last;
    logic [15:0] rx_frames;
  } port_t;

  port_t st;
  port_t next_st;
  logic rx_enable;
  logic tx_enable;
  logic mem_we;
  logic [31:0] mem_rdata;
  logic txc_take;
  logic txd_take;
  logic rx_take;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Counts valid bytes of an aligned beat; a one strobe marks a byte.
  function automatic logic [2:0] keep_bytes(input logic [3:0] keep);
    logic [2:0] n;
    n = 3'h0;
    for (int b = 0; b < eth_stream_pkg::KEEP_W; b++) begin
      n = n + {2'h0, keep[b]};
    end
    return n;
  endfunction

  // Offload is granted only where the build carries the requested kind.
  function automatic logic [1:0] resolve_offload(input logic [1:0] field, input logic loop);
    logic [1:0] mode;
    mode = eth_stream_pkg::OFFLOAD_NONE;
    if (!loop && field == eth_stream_pkg::OFFLOAD_PARTIAL
        && TX_OFFLOAD_BUILD_OPTION == eth_stream_pkg::OFFLOAD_PARTIAL) begin
      mode = eth_stream_pkg::OFFLOAD_PARTIAL;
    end
    if (!loop && field == eth_stream_pkg::OFFLOAD_FULL
        && TX_OFFLOAD_BUILD_OPTION == eth_stream_pkg::OFFLOAD_FULL) begin
      mode = eth_stream_pkg::OFFLOAD_FULL;
    end
    return mode;
  endfunction

  // Status words: flag word first, byte length in the sixth word.
  function automatic logic [31:0] status_word(input logic [2:0] idx, input logic [15:0] len);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (idx == 3'h0) begin
      w = {eth_stream_pkg::FLAG_RX_STATUS, 28'h000_0000};
    end
    if (idx == eth_stream_pkg::STATUS_LAST_IDX) begin
      w = {16'h0000, len};
    end
    return w;
  endfunction

  assign txc_take = st.txc_ready && i_txc_tvalid;
  assign txd_take = st.txd_ready && i_txd_tvalid;
  assign rx_take = st.mrx_ready && i_mac_rx_valid;
  // Words beyond the store depth are dropped; the frame still completes.
  assign mem_we = rx_take && !st.rx_words[9];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Transmit pairing, transmit forwarding and receive sequencing.
  always_comb begin
    next_st = st;
    // Transmit control packet; its strobes are never looked at.
    if (txc_take) begin
      next_st.ctrl_idx = (st.ctrl_idx == 3'h7) ? st.ctrl_idx : st.ctrl_idx + 3'h1;
      case (st.tx_state)
        eth_stream_pkg::TX_IDLE: begin
          next_st.ctrl_idx = 3'h1;
          next_st.csum_field = eth_stream_pkg::OFFLOAD_NONE;
          if (i_txc_tdata[31:28] == eth_stream_pkg::FLAG_NORMAL
              || i_txc_tdata[31:28] == eth_stream_pkg::FLAG_RX_STATUS) begin
            next_st.loopback = (i_txc_tdata[31:28] == eth_stream_pkg::FLAG_RX_STATUS);
            next_st.tx_state = i_txc_tlast ? eth_stream_pkg::TX_DATA : eth_stream_pkg::TX_CTRL;
            if (i_txc_tlast) begin
              next_st.offload = eth_stream_pkg::OFFLOAD_NONE;
            end
          end else begin
            next_st.ignored = st.ignored + 16'h0001;
            next_st.tx_state = i_txc_tlast ? eth_stream_pkg::TX_IDLE : eth_stream_pkg::TX_SKIP;
          end
        end
        eth_stream_pkg::TX_CTRL: begin
          // Only words one to three are kept; the trailing words are dropped.
          if (st.ctrl_idx == eth_stream_pkg::CTRL_WORD_OFFLOAD) begin
            next_st.csum_field = i_txc_tdata[1:0];
          end
          if (st.ctrl_idx == eth_stream_pkg::CTRL_WORD_POINTS) begin
            next_st.cs_begin = i_txc_tdata[31:16];
            next_st.cs_insert = i_txc_tdata[15:0];
          end
          if (st.ctrl_idx == eth_stream_pkg::CTRL_WORD_SEED) begin
            next_st.cs_init = i_txc_tdata[15:0];
          end
          if (i_txc_tlast) begin
            next_st.tx_state = eth_stream_pkg::TX_DATA;
            next_st.offload = resolve_offload(next_st.csum_field, st.loopback);
          end
        end
        eth_stream_pkg::TX_SKIP: begin
          if (i_txc_tlast) begin
            next_st.tx_state = eth_stream_pkg::TX_IDLE;
          end
        end
        default: begin
          next_st.tx_state = st.tx_state;
        end
      endcase
    end
    // Output slot toward the MAC drains when buffer space remains.
    if (st.mtx_valid && i_mac_tx_ready) begin
      next_st.mtx_valid = 1'b0;
    end
    // Data of any length is forwarded word by word until its last word.
    if (txd_take) begin
      next_st.mtx_valid = 1'b1;
      next_st.mtx_data = i_txd_tdata;
      next_st.mtx_keep = i_txd_tkeep;
      next_st.mtx_last = i_txd_tlast;
      if (i_txd_tlast) begin
        next_st.tx_state = eth_stream_pkg::TX_IDLE;
        next_st.tx_frames = st.tx_frames + 16'h0001;
      end
    end
    // Control waits for the previous last word to leave before a new frame.
    next_st.txc_ready = ((next_st.tx_state == eth_stream_pkg::TX_IDLE) && tx_enable
                         && !next_st.mtx_valid)
                        || next_st.tx_state == eth_stream_pkg::TX_CTRL
                        || next_st.tx_state == eth_stream_pkg::TX_SKIP;
    next_st.txd_ready = (next_st.tx_state == eth_stream_pkg::TX_DATA) && !next_st.mtx_valid
                        && i_mac_tx_ready;

    case (st.rx_state)
      eth_stream_pkg::RX_COLLECT: begin
        if (rx_take) begin
          if (mem_we) begin
            next_st.rx_words = st.rx_words + 10'h001;
            // Pad bytes are counted like payload and never subtracted.
            next_st.rx_bytes = st.rx_bytes + {13'h0000, keep_bytes(i_mac_rx_keep)};
            if (i_mac_rx_last) begin
              next_st.rx_last_keep = i_mac_rx_keep;
            end
          end
          if (i_mac_rx_last) begin
            next_st.rx_state = eth_stream_pkg::RX_STATUS;
            next_st.rxs_valid = 1'b1;
            next_st.rxs_idx = 3'h0;
            next_st.rxs_last = 1'b0;
            next_st.rxs_data = status_word(3'h0, next_st.rx_bytes);
          end
        end
      end
      eth_stream_pkg::RX_STATUS: begin
        if (st.rxs_valid && i_rxs_tready) begin
          if (st.rxs_last) begin
            // Data is offered only after the whole status packet has gone.
            next_st.rxs_valid = 1'b0;
            next_st.rxs_last = 1'b0;
            next_st.rx_state = eth_stream_pkg::RX_DATA;
            next_st.rxd_valid = 1'b1;
            next_st.rxd_data = mem_rdata;
            next_st.rd_ptr = 10'h001;
            next_st.rxd_last = (st.rx_words <= 10'h001);
            next_st.rxd_keep = (st.rx_words <= 10'h001) ? st.rx_last_keep
                                                         : eth_stream_pkg::KEEP_ALL;
          end else begin
            next_st.rxs_idx = st.rxs_idx + 3'h1;
            next_st.rxs_data = status_word(st.rxs_idx + 3'h1, st.rx_bytes);
            next_st.rxs_last = (st.rxs_idx + 3'h1 == eth_stream_pkg::STATUS_LAST_IDX);
          end
        end
      end
      eth_stream_pkg::RX_DATA: begin
        if (st.rxd_valid && i_rxd_tready) begin
          if (st.rxd_last) begin
            next_st.rxd_valid = 1'b0;
            next_st.rxd_last = 1'b0;
            next_st.rx_state = eth_stream_pkg::RX_COLLECT;
            next_st.rx_words = 10'h000;
            next_st.rx_bytes = 16'h0000;
            next_st.rx_last_keep = eth_stream_pkg::KEEP_ALL;
            next_st.rd_ptr = 10'h000;
            next_st.rx_frames = st.rx_frames + 16'h0001;
          end else begin
            next_st.rxd_data = mem_rdata;
            next_st.rd_ptr = st.rd_ptr + 10'h001;
            next_st.rxd_last = (st.rd_ptr + 10'h001 == st.rx_words);
            // Full strobes on every word but the last, which carries the strobes of the last stored MAC word.
            next_st.rxd_keep = (st.rd_ptr + 10'h001 == st.rx_words) ? st.rx_last_keep
                                                                  : eth_stream_pkg::KEEP_ALL;
          end
        end
      end
      default: begin
        next_st.rx_state = eth_stream_pkg::RX_COLLECT;
      end
    endcase
    next_st.mrx_ready = (next_st.rx_state == eth_stream_pkg::RX_COLLECT) && rx_enable;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Reset waits for a control packet with every outgoing valid low.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
      st.tx_state <= eth_stream_pkg::TX_IDLE;
      st.rx_state <= eth_stream_pkg::RX_COLLECT;
      st.rx_last_keep <= eth_stream_pkg::KEEP_ALL;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  rx_frame_store u_store (
    .i_ref_clk(i_ref_clk),
    .i_we(mem_we),
    .i_waddr(st.rx_words[8:0]),
    .i_wdata(i_mac_rx_data),
    .i_raddr(st.rd_ptr[8:0]),
    .o_rdata(mem_rdata)
  );

  eth_stream_regs u_regs (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_tx_state(st.tx_state),
    .i_rx_state(st.rx_state),
    .i_tx_frames(st.tx_frames),
    .i_rx_frames(st.rx_frames),
    .i_ignored(st.ignored),
    .o_pready(o_pready),
    .o_prdata(o_prdata),
    .o_pslverr(o_pslverr),
    .o_rx_enable(rx_enable),
    .o_tx_enable(tx_enable)
  );

  // Outputs come straight from the state register, except o_rxs_tkeep, which is tied to KEEP_ALL.
  assign o_txc_tready = st.txc_ready;
  assign o_txd_tready = st.txd_ready;
  assign o_mac_tx_data = st.mtx_data;
  assign o_mac_tx_keep = st.mtx_keep;
  assign o_mac_tx_valid = st.mtx_valid;
  assign o_mac_tx_last = st.mtx_last;
  assign o_mac_tx_offload = st.offload;
  assign o_mac_tx_loopback = st.loopback;
  assign o_tx_csum_begin = st.cs_begin;
  assign o_tx_csum_insert = st.cs_insert;
  assign o_tx_csum_init = st.cs_init;
  assign o_mac_rx_ready = st.mrx_ready;
  assign o_rxs_tdata = st.rxs_data;
  assign o_rxs_tkeep = eth_stream_pkg::KEEP_ALL;
  assign o_rxs_tvalid = st.rxs_valid;
  assign o_rxs_tlast = st.rxs_last;
  assign o_rxd_tdata = st.rxd_data;
  assign o_rxd_tkeep = st.rxd_keep;
  assign o_rxd_tvalid = st.rxd_valid;
  assign o_rxd_tlast = st.rxd_last;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence status_done_s;
    o_rxs_tvalid && o_rxs_tlast && i_rxs_tready;
  endsequence

  sequence ctrl_done_s;
    o_txc_tready && i_txc_tvalid && i_txc_tlast && st.tx_state == eth_stream_pkg::TX_CTRL;
  endsequence

  data_after_ctrl_a: assert property (o_txd_tready |-> st.tx_state == eth_stream_pkg::TX_DATA)
    else $error("data ready raised without an accepted control packet");
  ctrl_held_a: assert property (ctrl_done_s |=> !o_txc_tready [*2])
    else $error("control ready rose before the data packet ended");
  status_first_a: assert property (status_done_s |=> o_rxd_tvalid && !o_rxs_tvalid)
    else $error("receive data did not follow its status packet");
  data_no_status_a: assert property (o_rxd_tvalid |-> !o_rxs_tvalid)
    else $error("status and data offered together");
  status_hold_a: assert property (o_rxs_tvalid && !i_rxs_tready |=> o_rxs_tvalid && $stable(o_rxs_tdata))
    else $error("status word changed while stalled");
  rxd_hold_a: assert property (o_rxd_tvalid && !i_rxd_tready |=> o_rxd_tvalid && $stable(o_rxd_tdata))
    else $error("receive word changed while stalled");
  full_keep_a: assert property (o_rxd_tvalid && !o_rxd_tlast |-> o_rxd_tkeep == eth_stream_pkg::KEEP_ALL)
    else $error("partial strobes before the last word");
  packed_keep_a: assert property (o_rxd_tvalid && o_rxd_tlast |-> o_rxd_tkeep inside {4'h1, 4'h3, 4'h7, 4'hF})
    else $error("last word strobes not packed low");
  length_word_a: assert property (o_rxs_tvalid && o_rxs_tlast |-> o_rxs_tdata[15:0] == st.rx_bytes)
    else $error("status length differs from counted bytes");
  flag_word_a: assert property ($rose(o_rxs_tvalid) |-> o_rxs_tdata[31:28] == eth_stream_pkg::FLAG_RX_STATUS)
    else $error("status packet does not open with its flag");
  offload_build_a: assert property (o_mac_tx_offload != eth_stream_pkg::OFFLOAD_NONE |-> o_mac_tx_offload == TX_OFFLOAD_BUILD_OPTION)
    else $error("offload granted that the build lacks");
  mac_hold_a: assert property (o_mac_tx_valid && !i_mac_tx_ready |=> o_mac_tx_valid && $stable(o_mac_tx_data))
    else $error("transmit word changed while the MAC stalled");

endmodule

`default_nettype wire

// >>> design/eth_stream_pkg.sv
package eth_stream_pkg;

  localparam int WORD_W = 32;
  localparam int KEEP_W = 4;
  localparam int MEM_AW = 9;
  localparam int MEM_DEPTH = 512;
  localparam logic [3:0] KEEP_ALL = 4'hF;
  localparam logic [3:0] FLAG_NORMAL = 4'hA;
  localparam logic [3:0] FLAG_RX_STATUS = 4'h5;
  localparam logic [2:0] CTRL_WORD_OFFLOAD = 3'h1;
  localparam logic [2:0] CTRL_WORD_POINTS = 3'h2;
  localparam logic [2:0] CTRL_WORD_SEED = 3'h3;
  localparam logic [2:0] STATUS_LAST_IDX = 3'h5;
  localparam logic [1:0] OFFLOAD_NONE = 2'h0;
  localparam logic [1:0] OFFLOAD_PARTIAL = 2'h1;
  localparam logic [1:0] OFFLOAD_FULL = 2'h2;
  localparam logic [15:0] MIN_PADDED_LEN = 16'h003C;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_COUNT = 12'h008;
  localparam logic [11:0] REG_IGNORED = 12'h00C;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_CTRL = 4'h2,
    TX_SKIP = 4'h4,
    TX_DATA = 4'h8
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_COLLECT = 3'h1,
    RX_STATUS = 3'h2,
    RX_DATA = 3'h4
  } rx_state_t;

endpackage

// >>> design/rx_frame_store.sv
`timescale 1ns/1ps
`default_nettype none

module rx_frame_store (
  input wire logic i_ref_clk,
  input wire logic i_we,
  input wire logic [eth_stream_pkg::MEM_AW-1:0] i_waddr,
  input wire logic [eth_stream_pkg::WORD_W-1:0] i_wdata,
  input wire logic [eth_stream_pkg::MEM_AW-1:0] i_raddr,
  output logic [eth_stream_pkg::WORD_W-1:0] o_rdata
);

  // ---------------------------------------------------------------
  // Frame storage
  // ---------------------------------------------------------------
  logic [eth_stream_pkg::WORD_W-1:0] mem [eth_stream_pkg::MEM_DEPTH];

  // The write port stores one received word per accepted beat.
  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Reads are asynchronous so the caller can register the word itself.
  assign o_rdata = mem[i_raddr];

endmodule

`default_nettype wire

// >>> design/eth_stream_regs.sv
`timescale 1ns/1ps
`default_nettype none

module eth_stream_regs (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_tx_state,
  input wire logic [2:0] i_rx_state,
  input wire logic [15:0] i_tx_frames,
  input wire logic [15:0] i_rx_frames,
  input wire logic [15:0] i_ignored,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output logic o_rx_enable,
  output logic o_tx_enable
);

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [1:0] ctrl;
  } regs_t;

  regs_t st;
  regs_t next_st;
  logic hit;
  logic [31:0] rd;

  // ---------------------------------------------------------------
  // Decode and next state
  // ---------------------------------------------------------------
  // Answer is prepared in the setup cycle so the access phase has no wait.
  always_comb begin
    next_st = st;
    hit = 1'b1;
    rd = 32'h0000_0000;
    case (i_paddr)
      eth_stream_pkg::REG_CTRL: rd = {30'h0000_0000, st.ctrl};
      eth_stream_pkg::REG_STATUS: rd = {25'h000_0000, i_rx_state, i_tx_state};
      eth_stream_pkg::REG_COUNT: rd = {i_rx_frames, i_tx_frames};
      eth_stream_pkg::REG_IGNORED: rd = {16'h0000, i_ignored};
      default: hit = 1'b0;
    endcase
    next_st.pready = i_psel && !i_penable;
    if (i_psel && !i_penable) begin
      next_st.prdata = i_pwrite ? 32'h0000_0000 : rd;
      next_st.pslverr = !hit;
    end
    if (i_psel && i_penable && st.pready && i_pwrite && i_paddr == eth_stream_pkg::REG_CTRL) begin
      next_st.ctrl = i_pwdata[1:0];
    end
  end

  // State register.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
      st.ctrl <= eth_stream_pkg::CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign o_pready = st.pready;
  assign o_prdata = st.prdata;
  assign o_pslverr = st.pslverr;
  assign o_rx_enable = st.ctrl[0];
  assign o_tx_enable = st.ctrl[1];

endmodule

`default_nettype wire

// >>> verif/rx_dma_model.sv
`timescale 1ns/1ps
`default_nettype none
// System-side sink that throttles both receive streams in turn.
module rx_dma_model (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [31:0] i_rxs_tdata,
  input wire logic i_rxs_tvalid,
  input wire logic i_rxs_tlast,
  input wire logic i_rxd_tvalid,
  input wire logic i_rxd_tlast,
  output logic o_rxs_tready,
  output logic o_rxd_tready,
  output logic o_done,
  output logic o_order_err,
  output logic [15:0] o_len
);
  logic seen;
  // Ready alternates so each stream stalls every other cycle.
  assign o_rxd_tready = ~o_rxs_tready;
  // Strobes are never looked at; status must close before any data.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rxs_tready <= 1'b0;
      seen <= 1'b0;
      o_done <= 1'b0;
      o_order_err <= 1'b0;
      o_len <= 16'h0000;
    end else begin
      o_rxs_tready <= ~o_rxs_tready;
      if (i_rxs_tvalid && o_rxs_tready && i_rxs_tlast) begin
        o_len <= i_rxs_tdata[15:0];
        seen <= 1'b1;
      end
      if (i_rxd_tvalid && o_rxd_tready) begin
        o_order_err <= o_order_err | ~seen;
        o_done <= i_rxd_tlast;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/ethernet_stream_frame_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ethernet_stream_frame_port_tb;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pw = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, sd = 32'h0, prdata;
  logic [3:0] sk = 4'hF, mk, lk;
  logic sl = 1'b0, cv = 1'b0, dv = 1'b0, rv = 1'b0;
  logic pready, perr, ctr, dtr, mv, ml, mrr, lb, sv, sl_o, dvo, dlo, str, dtr_o, done, oerr;
  logic [1:0] off;
  logic [15:0] cb, cs, ci, len;
  logic [31:0] sdat, md, ld, rdt, rsum = 32'h0;
  logic [3:0] rk, rxk, stk;
  logic mtr = 1'b0;
  int n_errors = 0, num_checks = 0;
  always #20 clk = ~clk;
  ethernet_stream_frame_port uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pwd), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(perr), .i_txc_tdata(sd), .i_txc_tkeep(4'hF),
    .i_txc_tvalid(cv), .i_txc_tlast(sl), .o_txc_tready(ctr), .i_txd_tdata(sd),
    .i_txd_tkeep(sk), .i_txd_tvalid(dv), .i_txd_tlast(sl), .o_txd_tready(dtr),
    .o_mac_tx_data(md), .o_mac_tx_keep(mk), .o_mac_tx_valid(mv), .o_mac_tx_last(ml),
    .i_mac_tx_ready(mtr), .o_mac_tx_offload(off), .o_mac_tx_loopback(lb),
    .o_tx_csum_begin(cb), .o_tx_csum_insert(ci), .o_tx_csum_init(cs), .i_mac_rx_data(sd),
    .i_mac_rx_keep(sk), .i_mac_rx_valid(rv), .i_mac_rx_last(sl), .o_mac_rx_ready(mrr),
    .o_rxs_tdata(sdat), .o_rxs_tkeep(stk), .o_rxs_tvalid(sv), .o_rxs_tlast(sl_o),
    .i_rxs_tready(str), .o_rxd_tdata(rdt), .o_rxd_tkeep(rxk), .o_rxd_tvalid(dvo),
    .o_rxd_tlast(dlo), .i_rxd_tready(dtr_o));
  rx_dma_model dma (.i_ref_clk(clk), .i_rst_n(rst_n), .i_rxs_tdata(sdat), .i_rxs_tvalid(sv),
    .i_rxs_tlast(sl_o), .i_rxd_tvalid(dvo), .i_rxd_tlast(dlo), .o_rxs_tready(str),
    .o_rxd_tready(dtr_o), .o_done(done), .o_order_err(oerr), .o_len(len));
  // Keeps the last MAC word, sums received data and stalls the MAC every other cycle.
  always @(posedge clk) begin
    if (mv && ml) begin
      lk <= mk;
      ld <= md;
    end
    if (dvo && dtr_o) rsum <= rsum + rdt;
    if (dvo && dtr_o && dlo) rk <= rxk;
    mtr <= ~mtr;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One APB transfer; the request stands until pready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
           output logic er);
    psel <= 1'b1;
    pw <= w;
    pa <= a;
    pwd <= wd;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (!pready) @(posedge clk);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // One stream word on channel 0 control, 1 data, 2 MAC receive; held until taken.
  task put(input int ch, input logic [31:0] d, input logic [3:0] k, input logic l);
    sd <= d;
    sk <= k;
    sl <= l;
    cv <= (ch == 0);
    dv <= (ch == 1);
    rv <= (ch == 2);
    @(posedge clk);
    while (!(ch == 0 ? ctr : ch == 1 ? dtr : mrr)) @(posedge clk);
    if (l) begin
      cv <= 1'b0;
      dv <= 1'b0;
      rv <= 1'b0;
      @(posedge clk);
    end
  endtask
  task t_regs;
    logic [31:0] v;
    logic e;
    apb(1'b1, 12'h000, 32'h3, v, e);
    apb(1'b0, 12'h000, 32'h0, v, e);
    chk("ctrl", v, 32'h3);
    apb(1'b0, 12'h004, 32'h0, v, e);
    chk("status", v, 32'h11);
    apb(1'b0, 12'h010, 32'h0, v, e);
    chk("unmapped err", e, 32'h1);
    chk("unmapped data", v, 32'h0);
  endtask
  task t_tx(input logic [3:0] fl, input logic [1:0] fd, input logic [3:0] k,
            input logic [1:0] eo, input logic el);
    logic [31:0] w [6];
    w = '{{fl, 28'h0}, {30'h0, fd}, 32'h0010_0020, 32'h0000_BEEF, 32'hFFFF_FFFF, 32'h0};
    for (int i = 0; i < 6; i++) begin
      chk("txd_tready early", dtr, 32'h0);
      put(0, w[i], 4'hF, i == 5);
    end
    repeat (3) @(posedge clk);
    chk("txc_tready in data", ctr, 32'h0);
    chk("offload", off, eo);
    chk("loopback", lb, el);
    chk("csum begin", cb, 32'h10);
    chk("csum init", cs, 32'hBEEF);
    chk("csum insert", ci, 32'h20);
    put(1, 32'h1111_1111, 4'hF, 1'b0);
    put(1, 32'h3333_3333, k, 1'b1);
    repeat (4) @(posedge clk);
    chk("mac last keep", lk, k);
    chk("mac last data", ld, 32'h3333_3333);
  endtask
  task t_ign;
    logic [31:0] a, b;
    logic e;
    apb(1'b0, 12'h00C, 32'h0, a, e);
    for (int i = 0; i < 6; i++) begin
      chk("txd_tready ignored", dtr, 32'h0);
      put(0, i == 0 ? 32'h3000_0000 : 32'h0, 4'hF, i == 5);
    end
    repeat (2) @(posedge clk);
    apb(1'b0, 12'h00C, 32'h0, b, e);
    chk("ignored count", b, a + 32'h1);
  endtask
  task t_rx;
    for (int i = 0; i < 15; i++) put(2, i < 14 ? i + 1 : 0, 4'hF, i == 14);
    while (!done) @(posedge clk);
    chk("rx length", len, 32'h3C);
    chk("status first", oerr, 32'h0);
    chk("rx data sum", rsum, 32'h69);
    chk("rx last keep", rk, 32'hF);
    chk("status keep", stk, 32'hF);
  endtask
  // Main sequence after the reset span.
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_tx(4'hA, 2'h2, 4'h1, 2'h2, 1'b0);
    t_tx(4'hA, 2'h1, 4'hF, 2'h0, 1'b0);
    t_tx(4'hA, 2'h0, 4'h3, 2'h0, 1'b0);
    t_tx(4'hA, 2'h3, 4'h7, 2'h0, 1'b0);
    t_tx(4'h5, 2'h2, 4'hF, 2'h0, 1'b1);
    t_ign;
    t_rx;
    stop_test;
  end
  // Watchdog for a hung handshake.
  initial begin
    #400000;
    n_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
